// ### shared/qup_regs.svh
`ifndef QUP_REGS_SVH
`define QUP_REGS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define QUP_CLK_NS     50
`define QUP_SETUP_NS   300
`define QUP_STROBE_NS  600
`define QUP_HOLD_NS    400
`define QUP_CYC(ns)    (((ns) + `QUP_CLK_NS - 1) / `QUP_CLK_NS)
`define QUP_SETUP_CYC  `QUP_CYC(`QUP_SETUP_NS)
`define QUP_STROBE_CYC `QUP_CYC(`QUP_STROBE_NS)
`define QUP_HOLD_CYC   `QUP_CYC(`QUP_HOLD_NS)

// ****************************************
// Device registers and pin vector
// ****************************************
`define QUP_MCR_IDX    3'h4
`define QUP_MCR_IEN    3
`define QUP_STRAP_LAT  3'h4
`define QUP_STRAP_END  3'h5
`define QUP_IN_DATA    0
`define QUP_IN_ADDR    8
`define QUP_IN_WR      11
`define QUP_IN_RD      12
`define QUP_IN_CS      13
`define QUP_IN_FORCE   17
`define QUP_IN_STYLE   18
`define QUP_IN_W       19

// ****************************************
// Host software registers
// ****************************************
`define QUP_SW_CTRL    3'h0
`define QUP_SW_TARGET  3'h1
`define QUP_SW_WDATA   3'h2
`define QUP_SW_RDCMD   3'h3
`define QUP_SW_RDATA   3'h4
`define QUP_SW_STATUS  3'h5
`define QUP_SW_MASK    3'h6
`define QUP_CTRL_STYLE 0
`define QUP_CTRL_FORCE 1
`define QUP_CTRL_RST   2'h1
`define QUP_ST_DONE    0
`define QUP_ST_IRQ     1
`define QUP_HIN_W      12

`endif

// ### shared/qup_pkg.sv
`include "qup_regs.svh"

package qup_pkg;

  // Host bus cycle phases
  typedef enum logic [1:0] {
    QUP_IDLE,
    QUP_SETUP,
    QUP_STROBE,
    QUP_HOLD
  } qup_phase_e;

  // Device end state
  typedef struct packed {
    logic [2:0][`QUP_IN_W-1:0] sync;
    logic [`QUP_IN_W-1:0]      pin;
    logic [`QUP_IN_W-1:0]      prev;
    logic [2:0]                strap_cnt;
    logic                      style;
    logic                      wr_pend;
    logic [4:0]                wr_idx;
    logic [31:0][7:0]          regs;
    logic [7:0]                dout;
    logic                      dout_oe_n;
    logic [3:0]                irq_out;
    logic [3:0]                irq_oe_n;
    logic                      wr_done;
  } qup_dev_s;

  // Host end state
  typedef struct packed {
    logic [2:0][`QUP_HIN_W-1:0] sync;
    logic [`QUP_HIN_W-1:0]      pin;
    logic                       irq_prev;
    logic [1:0]                 ctrl;
    logic [4:0]                 target;
    logic [7:0]                 wdata;
    logic [7:0]                 rdata;
    logic [1:0]                 status;
    logic [1:0]                 mask;
    qup_phase_e                 phase;
    logic [4:0]                 cnt;
    logic                       is_read;
    logic [7:0]                 sw_rdata;
    logic                       irq;
    logic [7:0]                 dout;
    logic                       dout_oe_n;
    logic                       wr_n;
    logic                       rd_n;
    logic [3:0]                 cs_n;
    logic [2:0]                 addr;
  } qup_host_s;

endpackage

// ### shared/qup_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

interface qup_bus_if;

  // Strap and interrupt force
  logic       bus_style_select;
  logic       irq_output_force;
  // Strobes; write_strobe_n is read_write_select in line style
  logic       write_strobe_n;
  logic       read_strobe_n;
  // Selects a..d; b, c are chan_addr_lo, chan_addr_hi in line style
  logic [3:0] chan_select_n;
  logic [2:0] reg_addr;
  // Data bus, both drivers
  logic [7:0] host_data_out;
  logic       host_data_oe_n;
  logic [7:0] dev_data_out;
  logic       dev_data_oe_n;
  logic [7:0] data_bus;
  // Interrupt pins
  logic [3:0] irq_out;
  logic [3:0] irq_oe_n;
  logic [3:0] irq_level;
  logic       chan_addr_lo;
  logic       chan_addr_hi;

  // Wire levels; undriven bus floats high
  assign data_bus = !host_data_oe_n ? host_data_out :
                    !dev_data_oe_n  ? dev_data_out  : 8'hff;
  assign chan_addr_lo = chan_select_n[1];
  assign chan_addr_hi = chan_select_n[2];

  // Shared request pulled up in line style, else undriven reads low
  always_comb
  begin
    irq_level = irq_out;
    for (int i = 0; i < 4; i++)
    begin
      if (irq_oe_n[i])
        irq_level[i] = (i == 0) && !bus_style_select;
    end
  end

  modport device (
    input  bus_style_select, irq_output_force, write_strobe_n,
    input  read_strobe_n, chan_select_n, reg_addr, data_bus,
    output dev_data_out, dev_data_oe_n, irq_out, irq_oe_n
  );

  modport host (
    output bus_style_select, irq_output_force, write_strobe_n,
    output read_strobe_n, chan_select_n, reg_addr,
    output host_data_out, host_data_oe_n,
    input  data_bus, irq_level
  );

endinterface

`default_nettype wire

// ### core/qup_host.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "qup_regs.svh"

module qup_host
  import qup_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Device link
  qup_bus_if.host         bus,
  // Software port
  input  wire logic [2:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  output logic            irq
);

  // Filter starts at idle pin levels, so no false interrupt edge
  localparam qup_host_s HOST_RST = '{
    sync: {3{12'h0ff}}, pin: 12'h0ff, ctrl: `QUP_CTRL_RST, phase: QUP_IDLE,
    dout_oe_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, cs_n: 4'hf,
    default: '0};

  qup_host_s q;
  qup_host_s d;
  logic [`QUP_HIN_W-1:0] agree;
  logic [1:0]            set;
  logic [1:0]            clr;
  logic                  dev_irq;
  logic                  style;
  logic                  start;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    set = 2'h0;
    clr = 2'h0;
    start = 1'b0;
    style = q.ctrl[`QUP_CTRL_STYLE];
    // Three-stage pin sampling, change taken when stages agree
    d.sync = {q.sync[1:0], bus.irq_level, bus.data_bus};
    agree = ~(q.sync[1] ^ q.sync[2]);
    d.pin = (q.pin & ~agree) | (q.sync[2] & agree);
    // Device request seen on the interrupt pins
    dev_irq = style ? |q.pin[11:8] : ~q.pin[8];
    set[`QUP_ST_IRQ] = dev_irq & ~q.irq_prev;
    d.irq_prev = dev_irq;
    // Software reads
    d.sw_rdata = 8'h00;
    if (sw_rd)
    begin
      case (sw_addr)
        `QUP_SW_CTRL:   d.sw_rdata = {6'h0, q.ctrl};
        `QUP_SW_TARGET: d.sw_rdata = {3'h0, q.target};
        `QUP_SW_WDATA:  d.sw_rdata = q.wdata;
        `QUP_SW_RDATA:  d.sw_rdata = q.rdata;
        `QUP_SW_STATUS:
        begin
          d.sw_rdata = {5'h0, q.phase != QUP_IDLE, q.status};
          clr = 2'h3;
        end
        `QUP_SW_MASK:   d.sw_rdata = {6'h0, q.mask};
        default:        d.sw_rdata = 8'h00;
      endcase
    end
    // Software writes; a start while busy is dropped
    if (sw_wr)
    begin
      case (sw_addr)
        `QUP_SW_CTRL:   d.ctrl = sw_wdata[1:0];
        `QUP_SW_TARGET: d.target = sw_wdata[4:0];
        `QUP_SW_WDATA:
        begin
          d.wdata = sw_wdata;
          start = q.phase == QUP_IDLE;
          d.is_read = 1'b0;
        end
        `QUP_SW_RDCMD:
        begin
          start = q.phase == QUP_IDLE;
          d.is_read = 1'b1;
        end
        `QUP_SW_MASK:   d.mask = sw_wdata[1:0];
        default:        d.mask = q.mask;
      endcase
    end
    // Bus cycle sequencer
    case (q.phase)
      QUP_IDLE:
      begin
        if (start)
        begin
          d.phase = QUP_SETUP;
          d.cnt = 5'(`QUP_SETUP_CYC - 1);
          d.addr = q.target[2:0];
          d.dout = sw_wdata;
          d.dout_oe_n = d.is_read;
          if (style)
            d.cs_n = ~(4'h1 << q.target[4:3]);
          else
            d.cs_n = {1'b1, q.target[4:3], 1'b1};
          d.wr_n = style ? 1'b1 : d.is_read;
        end
      end
      QUP_SETUP:
      begin
        d.cnt = q.cnt - 5'h1;
        if (q.cnt == 5'h0)
        begin
          d.phase = QUP_STROBE;
          d.cnt = 5'(`QUP_STROBE_CYC - 1);
          if (!style)
            d.cs_n[0] = 1'b0;
          else if (q.is_read)
            d.rd_n = 1'b0;
          else
            d.wr_n = 1'b0;
        end
      end
      QUP_STROBE:
      begin
        d.cnt = q.cnt - 5'h1;
        if (q.cnt == 5'h0)
        begin
          d.phase = QUP_HOLD;
          d.cnt = 5'(`QUP_HOLD_CYC - 1);
          if (q.is_read)
            d.rdata = q.pin[7:0];
          if (style)
          begin
            d.rd_n = 1'b1;
            d.wr_n = 1'b1;
          end
          else
            d.cs_n[0] = 1'b1;
        end
      end
      QUP_HOLD:
      begin
        d.cnt = q.cnt - 5'h1;
        if (q.cnt == 5'h0)
        begin
          d.phase = QUP_IDLE;
          d.cs_n = 4'hf;
          d.wr_n = 1'b1;
          d.dout_oe_n = 1'b1;
          set[`QUP_ST_DONE] = 1'b1;
        end
      end
      default: d.phase = QUP_IDLE;
    endcase
    // Sticky status, set wins over read clear
    d.status = (q.status & ~clr) | set;
    d.irq = |(d.status & d.mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= HOST_RST;
    else
      q <= d;
  end

  // Pins and user outputs from flops, force pin is the force bit gated by the style bit
  assign bus.bus_style_select = q.ctrl[`QUP_CTRL_STYLE];
  assign bus.irq_output_force =
    q.ctrl[`QUP_CTRL_FORCE] & q.ctrl[`QUP_CTRL_STYLE];
  assign bus.write_strobe_n = q.wr_n;
  assign bus.read_strobe_n = q.rd_n;
  assign bus.chan_select_n = q.cs_n;
  assign bus.reg_addr = q.addr;
  assign bus.host_data_out = q.dout;
  assign bus.host_data_oe_n = q.dout_oe_n;
  assign sw_rdata = q.sw_rdata;
  assign irq = q.irq;

endmodule

`default_nettype wire

// ### core/qup_device.sv
`timescale 1ns/1ps
`default_nettype none

`include "qup_regs.svh"

module qup_device
  import qup_pkg::*;
#(
  parameter bit FORCE_PIN = 1'b1,
  parameter bit FORCE_TIE = 1'b0
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Host link
  qup_bus_if.device       bus,
  // Channel cores
  input  wire logic [3:0] chan_irq_req,
  output logic      [3:0] irq_enable,
  output logic            style,
  output logic            wr_done
);

  // Idle pin levels: bus floats high, force pin pulled low
  localparam logic [`QUP_IN_W-1:0] PIN_IDLE =
    {1'b1, 1'b0, {(`QUP_IN_W - 2){1'b1}}};

  localparam qup_dev_s DEV_RST = '{
    sync: {3{PIN_IDLE}}, pin: PIN_IDLE, prev: PIN_IDLE, style: 1'b1,
    dout_oe_n: 1'b1, irq_oe_n: 4'hf, default: '0};

  // ****************************************
  // Helpers
  // ****************************************

  // Channel hit and number from the select pins
  function automatic logic [2:0] chan_decode(
    input logic       strobe_style,
    input logic [3:0] cs_n
  );
    logic [2:0] r;
    r = 3'h0;
    if (strobe_style)
    begin
      case (cs_n)
        4'he:    r = 3'h4;
        4'hd:    r = 3'h5;
        4'hb:    r = 3'h6;
        4'h7:    r = 3'h7;
        default: r = 3'h0;
      endcase
    end
    else
      r = {~cs_n[0], cs_n[2], cs_n[1]};
    return r;
  endfunction

  // Interrupt output enable bit of one channel
  function automatic logic irq_en_of(
    input logic [31:0][7:0] regs,
    input logic [1:0]       ch
  );
    logic [7:0] modem_control_reg;
    modem_control_reg = regs[{ch, `QUP_MCR_IDX}];
    return modem_control_reg[`QUP_MCR_IEN];
  endfunction

  qup_dev_s q;
  qup_dev_s d;
  logic [`QUP_IN_W-1:0] pins_in;
  logic [`QUP_IN_W-1:0] agree;
  logic [3:0]           cs;
  logic [2:0]           dec;
  logic [4:0]           idx;
  logic                 wr_lvl;
  logic                 wr_prev;
  logic                 wr_ok;
  logic                 rd_act;
  logic                 force_eff;

  // ****************************************
  // Pin gathering
  // ****************************************

  // All link inputs as one vector
  assign pins_in = {
    bus.bus_style_select,
    bus.irq_output_force,
    bus.chan_select_n,
    bus.read_strobe_n,
    bus.write_strobe_n,
    bus.reg_addr,
    bus.data_bus
  };

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.wr_done = 1'b0;

    // Three-stage sampling, a change counts when stages agree
    d.sync = {q.sync[1:0], pins_in};
    agree = ~(q.sync[1] ^ q.sync[2]);
    d.pin = (q.pin & ~agree) | (q.sync[2] & agree);
    d.prev = q.pin;

    // Strap taken once the filter has settled
    if (q.strap_cnt != `QUP_STRAP_END)
      d.strap_cnt = q.strap_cnt + 3'h1;
    if (q.strap_cnt == `QUP_STRAP_LAT)
      d.style = q.pin[`QUP_IN_STYLE];

    // Access decode in the strapped style
    cs = q.pin[`QUP_IN_CS +: 4];
    dec = chan_decode(q.style, cs);
    idx = {dec[1:0], q.pin[`QUP_IN_ADDR +: 3]};

    // Write timing line: strobe, or the select in line style
    wr_lvl = q.style ? q.pin[`QUP_IN_WR] : cs[0];
    wr_prev = q.style ? q.prev[`QUP_IN_WR] : q.prev[`QUP_IN_CS];
    wr_ok = q.style ? dec[2]
                    : ~q.pin[`QUP_IN_WR];

    // Falling edge opens the write and fixes the target
    if (wr_prev && !wr_lvl && wr_ok)
    begin
      d.wr_pend = 1'b1;
      d.wr_idx = idx;
    end

    // Rising edge stores the bus byte
    if (!wr_prev && wr_lvl && q.wr_pend)
    begin
      d.regs[q.wr_idx] = q.pin[`QUP_IN_DATA +: 8];
      d.wr_pend = 1'b0;
      d.wr_done = 1'b1;
    end

    // Read drive while the access stands
    if (q.style)
      rd_act = !q.pin[`QUP_IN_RD] && dec[2];
    else
      rd_act = !cs[0] && q.pin[`QUP_IN_WR];
    d.dout = q.regs[idx];
    d.dout_oe_n = !rd_act;

    // Force level: pin, or tied per variant
    force_eff = FORCE_PIN ? q.pin[`QUP_IN_FORCE]
                          : FORCE_TIE;

    // Interrupt pins per strapped style
    if (q.style)
    begin
      d.irq_out = chan_irq_req;
      for (int i = 0; i < 4; i++)
      begin
        d.irq_oe_n[i] = !(force_eff
                        || irq_en_of(q.regs, 2'(i)));
      end
    end
    else
    begin
      d.irq_out = 4'h0;
      d.irq_oe_n[0] = !(|chan_irq_req);
      d.irq_oe_n[3:1] = 3'h0;
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Reset clears every enable bit, interrupts float
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= DEV_RST;
    else
      q <= d;
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Link drivers, all from flops
  assign bus.dev_data_out = q.dout;
  assign bus.dev_data_oe_n = q.dout_oe_n;
  assign bus.irq_out = q.irq_out;
  assign bus.irq_oe_n = q.irq_oe_n;

  // Enable bits straight from the stored registers
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      irq_enable[i] = irq_en_of(q.regs, 2'(i));
  end

  assign style = q.style;
  assign wr_done = q.wr_done;

endmodule

`default_nettype wire

// ### tb/qup_props.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Link pin checker
// ****************************************
module qup_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Link signals
  input wire logic       bus_style_select,
  input wire logic       irq_output_force,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [3:0] chan_select_n,
  input wire logic       dev_data_oe_n,
  input wire logic [3:0] irq_out,
  input wire logic [3:0] irq_oe_n
);
  logic [3:0] settle_q;
  logic       settled;

  // Edges since reset release, skips the strap window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      settle_q <= 4'h0;
    else if (settle_q != 4'hf)
      settle_q <= settle_q + 4'h1;
  end
  assign settled = (settle_q > 4'h9);

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reset_quiet: assert property (
    $rose(reset_n) |-> irq_oe_n == 4'hf && dev_data_oe_n)
    else $error("pins driven right after reset");
  a_line_irq_low: assert property (
    settled && !bus_style_select |-> irq_oe_n[3:1] == 3'h0 &&
    irq_out[3:1] == 3'h0)
    else $error("unused interrupt pins not held low");
  a_shared_req_od: assert property (
    settled && !bus_style_select && !irq_oe_n[0] |-> !irq_out[0])
    else $error("shared request driven high");
  a_force_all_on: assert property (
    (settled && bus_style_select && irq_output_force) [*8]
    |-> irq_oe_n == 4'h0)
    else $error("force pin did not enable interrupts");
  a_read_drives: assert property (
    (settled && bus_style_select && !read_strobe_n &&
     $onehot(~chan_select_n)) [*8] |-> !dev_data_oe_n)
    else $error("read strobe without data driven");
  a_read_idle_quiet: assert property (
    (settled && bus_style_select && read_strobe_n) [*8]
    |-> dev_data_oe_n)
    else $error("data driven without read strobe");
  a_line_rd_drive: assert property (
    (settled && !bus_style_select && write_strobe_n &&
     !chan_select_n[0]) [*8] |-> !dev_data_oe_n)
    else $error("line style read not driven");
  a_line_wr_quiet: assert property (
    (settled && !bus_style_select && !write_strobe_n) [*8]
    |-> dev_data_oe_n)
    else $error("line style write drove data");
endmodule

`default_nettype wire

// ### tb/tb_quad_uart_host_bus_and_irq_pins.sv
`timescale 1ns/1ps
`default_nettype none

`include "qup_regs.svh"

// ****************************************
// Both ends with software port stimulus
// ****************************************
module tb_quad_uart_host_bus_and_irq_pins;
  logic       clk;
  logic       rst_n;
  logic       dev_rst_n;
  logic [2:0] sw_addr;
  logic [7:0] sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  logic [7:0] sw_rdata;
  logic       irq;
  logic [3:0] chan_irq_req;
  logic [3:0] irq_enable;
  logic       style;
  logic       wr_done;
  logic [7:0] rd;
  int         miscompares;
  int         compares;
  int         cycles;
  int         wr_count;

  qup_bus_if qup_bus_if_inst ();

  qup_host qup_host_inst (.clk(clk), .reset_n(rst_n), .bus(qup_bus_if_inst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq(irq));

  qup_device qup_device_inst (.clk(clk), .reset_n(dev_rst_n),
    .bus(qup_bus_if_inst), .chan_irq_req(chan_irq_req),
    .irq_enable(irq_enable), .style(style), .wr_done(wr_done));

  qup_props qup_props_inst (.clk(clk), .reset_n(dev_rst_n),
    .bus_style_select(qup_bus_if_inst.bus_style_select),
    .irq_output_force(qup_bus_if_inst.irq_output_force),
    .write_strobe_n(qup_bus_if_inst.write_strobe_n),
    .read_strobe_n(qup_bus_if_inst.read_strobe_n),
    .chan_select_n(qup_bus_if_inst.chan_select_n),
    .dev_data_oe_n(qup_bus_if_inst.dev_data_oe_n),
    .irq_out(qup_bus_if_inst.irq_out),
    .irq_oe_n(qup_bus_if_inst.irq_oe_n));

  // Second device end, force pin tied high inside, idle host levels
  qup_bus_if tie_bus_if_inst ();

  qup_device #(.FORCE_PIN(1'b0), .FORCE_TIE(1'b1)) qup_device_tie_inst (
    .clk(clk), .reset_n(dev_rst_n), .bus(tie_bus_if_inst),
    .chan_irq_req(chan_irq_req), .irq_enable(), .style(), .wr_done());

  assign tie_bus_if_inst.bus_style_select = 1'b1;
  assign tie_bus_if_inst.irq_output_force = 1'b0;
  assign tie_bus_if_inst.write_strobe_n = 1'b1;
  assign tie_bus_if_inst.read_strobe_n = 1'b1;
  assign tie_bus_if_inst.chan_select_n = 4'hf;
  assign tie_bus_if_inst.reg_addr = 3'h0;
  assign tie_bus_if_inst.host_data_out = 8'h00;
  assign tie_bus_if_inst.host_data_oe_n = 1'b1;

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (wr_done === 1'b1)
      wr_count <= wr_count + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe
  task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Poll the sticky done bit, bounded
  task automatic wait_done();
    logic [7:0] s;
    int         n;
    s = 8'h00;
    n = 0;
    while (!s[`QUP_ST_DONE] && n < 80)
    begin
      sw_read(`QUP_SW_STATUS, s);
      n++;
    end
    check({7'h00, s[`QUP_ST_DONE]}, 8'h01);
  endtask

  task automatic bus_wr(input logic [4:0] t, input logic [7:0] d);
    sw_write(`QUP_SW_TARGET, {3'h0, t});
    sw_write(`QUP_SW_WDATA, d);
    wait_done();
  endtask

  task automatic bus_rd(input logic [4:0] t, input logic [7:0] exp);
    sw_write(`QUP_SW_TARGET, {3'h0, t});
    sw_write(`QUP_SW_RDCMD, 8'h00);
    wait_done();
    sw_read(`QUP_SW_RDATA, rd);
    check(rd, exp);
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    dev_rst_n = 1'b0;
    sw_addr = 3'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    chan_irq_req = 4'h0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    wr_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    settle(1);
    check({4'h0, irq_enable}, 8'h00);
    check({4'h0, qup_bus_if_inst.irq_oe_n}, 8'h0f);
    settle(8);
    check({7'h00, style}, 8'h01);
    check({4'h0, tie_bus_if_inst.irq_oe_n}, 8'h00);
    // One byte per channel, then read all back
    for (int c = 0; c < 4; c++)
      bus_wr({c[1:0], 3'h3}, 8'h50 + c[7:0]);
    for (int c = 0; c < 4; c++)
      bus_rd({c[1:0], 3'h3}, 8'h50 + c[7:0]);
    // Enable bit of channel 1 only
    bus_wr(5'h0c, 8'h08);
    settle(2);
    check({4'h0, irq_enable}, 8'h02);
    check({4'h0, qup_bus_if_inst.irq_oe_n}, 8'h0d);
    check(wr_count[7:0], 8'h05);
    // Force pin, interrupt raise, mask, clear
    @(posedge clk);
    chan_irq_req <= 4'h4;
    sw_write(`QUP_SW_CTRL, 8'h03);
    settle(10);
    check({4'h0, qup_bus_if_inst.irq_oe_n}, 8'h00);
    check({7'h00, irq}, 8'h00);
    sw_write(`QUP_SW_MASK, 8'h02);
    settle(3);
    check({7'h00, irq}, 8'h01);
    sw_read(`QUP_SW_STATUS, rd);
    check(rd & 8'h02, 8'h02);
    settle(3);
    check({7'h00, irq}, 8'h00);
    sw_write(`QUP_SW_CTRL, 8'h01);
    settle(10);
    check({4'h0, qup_bus_if_inst.irq_oe_n}, 8'h0d);
    // Restrap to line style under device reset
    @(posedge clk);
    dev_rst_n <= 1'b0;
    chan_irq_req <= 4'h0;
    sw_write(`QUP_SW_CTRL, 8'h00);
    @(posedge clk);
    dev_rst_n <= 1'b1;
    settle(10);
    check({7'h00, style}, 8'h00);
    check({7'h00, qup_bus_if_inst.chan_select_n[3]}, 8'h01);
    check({7'h00, qup_bus_if_inst.irq_output_force}, 8'h00);
    check({qup_bus_if_inst.irq_oe_n, qup_bus_if_inst.irq_out}, 8'h10);
    check({4'h0, qup_bus_if_inst.irq_level}, 8'h01);
    @(posedge clk);
    chan_irq_req <= 4'h8;
    settle(8);
    check({qup_bus_if_inst.irq_oe_n, qup_bus_if_inst.irq_out}, 8'h00);
    check({4'h0, qup_bus_if_inst.irq_level}, 8'h00);
    @(posedge clk);
    chan_irq_req <= 4'h0;
    // Channel chosen by the address bits
    bus_wr(5'h15, 8'ha5);
    bus_wr(5'h1d, 8'h3c);
    bus_rd(5'h15, 8'ha5);
    bus_rd(5'h1d, 8'h3c);
    bus_rd(5'h0b, 8'h00);
    check(wr_count[7:0], 8'h07);
    complete_run();
  end
endmodule

`default_nettype wire
